//--- bench/ech_dispatch_model.sv
`timescale 1ns/1ps
module ech_dispatch_model (
   // Clock
   input  wire       clk_sys,
   // Issue side
   output reg        issueAValid = 1'b0, issueBValid = 1'b0, elimRelease = 1'b0,
   output reg        issueAPartial = 1'b0, issueBPartial = 1'b0,
   output reg  [2:0] issueAOp = 3'h0, issueAMove = 3'h0, issueAPort = 3'h0,
   output reg  [2:0] issueBOp = 3'h0, issueBMove = 3'h0, issueBPort = 3'h0,
   output reg  [1:0] issueASrcDom = 2'h0, issueBSrcDom = 2'h0,
   output reg  [7:0] issueAAge = 8'h00, issueBAge = 8'h00
);
   // One dispatch cycle; both slots carry the same kind so they contend
   task send(input [2:0] op, input [1:0] dom, input [2:0] mv, input [2:0] port,
             input [7:0] ageA, input [7:0] ageB, input bOn, input rel);
      @(posedge clk_sys);
      {issueAOp, issueBOp, issueASrcDom, issueBSrcDom} <= {op, op, dom, dom};
      {issueAMove, issueBMove, issueAPort, issueBPort} <= {mv, mv, port, port};
      {issueAAge, issueBAge, issueAPartial, issueBPartial} <= {ageA, ageB, mv[0], ~mv[0]};
      {issueAValid, issueBValid, elimRelease} <= {1'b1, bOn, rel};
      @(posedge clk_sys);
      // Stale op fields are inverted so a dropped request never looks live
      {issueAValid, issueBValid, elimRelease} <= 3'h0;
      {issueAOp, issueBOp} <= ~{op, op};
   endtask
endmodule // ech_dispatch_model

//--- bench/ech_exec_hazard_bench.sv
`timescale 1ns/1ps
module ech_exec_hazard_bench;
   reg         clk_sys = 1'b0;
   reg         rst_n = 1'b0;
   wire        issueAValid, issueBValid, issueAPartial, issueBPartial, elimRelease;
   wire [2:0]  issueAOp, issueAMove, issueAPort, issueBOp, issueBMove, issueBPort;
   wire [1:0]  issueASrcDom, issueBSrcDom;
   wire [7:0]  issueAAge, issueBAge;
   wire        grantA, grantB, stallA, stallB, elimA, elimB, mergeUopA, mergeUopB;
   wire [3:0]  latencyA, latencyB;
   wire [2:0]  portA, portB, elimFree;
   wire [3:0]  latNew;
   wire [2:0]  portNew;
   int         miscompares = 0, checks_done = 0, cycles = 0, seed = 25, freeCnt = 4;
   logic       pend = 1'b0, el;
   logic [2:0] rp, mv;
   logic [7:0] age;
   logic [10:0] expQ[$];
   logic [10:0] e;
   // Op, source domain, latency
   localparam logic [8:0] TBL [7] = '{9'h053, 9'h064, 9'h0A1, 9'h092, 9'h0C1, 9'h0D2, 9'h001};
   ech_exec_hazard i_ech_exec_hazard (.*);
   // Newest generation, fed the same stimulus
   ech_exec_hazard #(.NEW_GEN(1)) i_ech_exec_hazard_newgen (
      .clk_sys(clk_sys), .rst_n(rst_n), .issueAValid(issueAValid), .issueAOp(issueAOp),
      .issueASrcDom(issueASrcDom), .issueAMove(issueAMove), .issueAPort(issueAPort),
      .issueAAge(issueAAge), .issueAPartial(issueAPartial), .issueBValid(issueBValid),
      .issueBOp(issueBOp), .issueBSrcDom(issueBSrcDom), .issueBMove(issueBMove),
      .issueBPort(issueBPort), .issueBAge(issueBAge), .issueBPartial(issueBPartial),
      .elimRelease(elimRelease), .grantA(), .grantB(), .stallA(), .stallB(),
      .latencyA(latNew), .latencyB(), .portA(portNew), .portB(), .elimA(), .elimB(),
      .mergeUopA(), .mergeUopB(), .elimFree());
   ech_dispatch_model i_ech_dispatch_model (.*);
   always #50 clk_sys = ~clk_sys;
   task check(input logic [3:0] seen, input logic [3:0] want);
      checks_done++;
      if (seen !== want) begin
         miscompares++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, want);
      end
   endtask
   task conclude;
      $display("comparisons %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   // Note: {stallA, stallB, elimA, latency, port checked, port}
   task issue(input [2:0] op, input [1:0] dom, input [2:0] m, input [2:0] port,
              input [7:0] aAge, input [7:0] bAge, input bOn, input rel, input [10:0] want);
      expQ.push_back(want);
      i_ech_dispatch_model.send(op, dom, m, port, aAge, bAge, bOn, rel);
      repeat (6) @(posedge clk_sys);
   endtask
   // ****************************************
   // Result watcher
   // ****************************************
   always @(posedge clk_sys) pend <= issueAValid && rst_n;
   always @(negedge clk_sys) begin
      cycles++;
      if (cycles == 1000) begin
         miscompares++;
         conclude;
      end
      if (pend && expQ.size() > 0) begin
         e = expQ.pop_front();
         check({stallA, stallB, elimA, mergeUopA}, {e[10:8], 1'b0});
         if (!e[10]) check(latencyA, e[7:4]);
         if (e[3]) check({1'b0, portA}, {1'b0, e[2:0]});
         if (e[3]) check(latNew, 4'h3);
         if (e[3]) check({1'b0, portNew}, 4'h1);
      end
   end
   // ****************************************
   // Scenarios
   // ****************************************
   initial begin
      repeat (2) @(posedge clk_sys);
      rst_n <= 1'b1;
      foreach (TBL[k])
         issue(TBL[k][8:6], TBL[k][5:4], 3'h0, 3'h0, 8'h00, 8'h00, 1'b0, 1'b0,
               {3'b000, TBL[k][3:0], 4'h0});
      repeat (3) begin
         rp = $random(seed);
         issue(3'h5, 2'h0, 3'h0, rp, 8'h00, 8'h00, 1'b0, 1'b0,
               {3'b000, 4'h2, 1'b1, (rp == 3'h5) ? 3'h5 : 3'h1});
      end
      // Ineligible kinds first, then drain the slots, then hand one back
      for (int m = 0; m < 11; m++) begin
         mv = (m < 4) ? 3'(m + 4) : 3'(m & 3);
         el = (m != 9) && !mv[2] && freeCnt > 0;
         if (el) freeCnt--;
         if (m == 9) freeCnt++;
         issue((m == 9) ? 3'h2 : 3'h4, (m == 9) ? 2'h2 : 2'h0, mv, 3'h0, 8'h00, 8'h00, 1'b0,
               m == 9, {2'b00, el, el ? 4'h0 : 4'h1, 4'h0});
         if (m == 8) check({1'b0, elimFree}, 4'h0);
      end
      age = 8'h01 + ($random(seed) & 8'h7F);
      issue(3'h2, 2'h2, 3'h0, 3'h0, age, age + 8'h01, 1'b1, 1'b0, {3'b010, 4'h1, 4'h0});
      issue(3'h2, 2'h2, 3'h0, 3'h0, age + 8'h01, age, 1'b1, 1'b0, {3'b100, 4'h1, 4'h0});
      issue(3'h2, 2'h2, 3'h0, 3'h0, age + 8'h01, age, 1'b0, 1'b0, {3'b000, 4'h1, 4'h0});
      // Add claims the bus; a one-cycle op issued two cycles later lands on that slot
      expQ.push_back({3'b000, 4'h3, 4'h0});
      expQ.push_back({3'b100, 4'h1, 4'h0});
      i_ech_dispatch_model.send(3'h1, 2'h1, 3'h0, 3'h0, 8'h00, 8'h01, 1'b0, 1'b0);
      i_ech_dispatch_model.send(3'h0, 2'h0, 3'h0, 3'h0, 8'h00, 8'h01, 1'b0, 1'b0);
      repeat (6) @(posedge clk_sys);
      conclude;
   end
endmodule // ech_exec_hazard_bench

//--- bench/ech_hazard_assertions.sv
`timescale 1ns/1ps
module ech_hazard_checker #(parameter NEW_GEN = 0) (
   // Clock, reset and issue side, plus the portA and elimFree results
   input wire logic       clk_sys, rst_n, issueAValid, issueBValid, elimRelease,
   input wire logic [2:0] issueAOp, issueAMove, issueBOp, portA, elimFree,
   input wire logic [1:0] issueASrcDom, issueBSrcDom,
   input wire logic [7:0] issueAAge, issueBAge,
   // Results
   input wire logic       grantB, stallA, elimA, mergeUopA, mergeUopB,
   input wire logic [3:0] latencyA
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   wire [4:0] aKind = {issueAOp, issueASrcDom};
   property p_fadd; issueAValid && aKind == 5'h05 |=> stallA || latencyA == 4'h3; endproperty
   a_fadd: assert property (p_fadd) else $error("add latency wrong");
   property p_packed_bitwise_and; issueAValid && aKind == 5'h0A |=> stallA || latencyA == 4'h1; endproperty
   a_packed_bitwise_and: assert property (p_packed_bitwise_and) else $error("and latency wrong");
   property p_xdom; issueAValid && aKind == 5'h09 |=> stallA || latencyA == 4'h2; endproperty
   a_xdom: assert property (p_xdom) else $error("crossing cost wrong");
   property p_fpld; issueAValid && aKind == 5'h0D |=> stallA || latencyA == 4'h2; endproperty
   a_fpld: assert property (p_fpld) else $error("fp load latency wrong");
   property p_hb; issueAValid && issueAOp == 3'h5 |=> stallA ||
      (latencyA == (NEW_GEN ? 4'h3 : 4'h2) && (portA == 3'h1 || (!NEW_GEN && portA == 3'h5)));
   endproperty
   a_hb: assert property (p_hb) else $error("high byte handling wrong");
   // Equal kinds mean equal latency, so the younger one must lose the slot
   property p_older; issueAValid && issueBValid && issueAOp == issueBOp && issueAOp != 3'h4 &&
      issueASrcDom == issueBSrcDom && issueAAge <= issueBAge |=> !grantB; endproperty
   a_older: assert property (p_older) else $error("younger op granted");
   property p_elim; elimA |-> latencyA == 4'h0 && !stallA; endproperty
   a_elim: assert property (p_elim) else $error("eliminated move not free");
   property p_noelim; issueAValid && issueAOp == 3'h4 &&
      (issueAMove[2] || (elimFree == 3'h0 && !elimRelease)) |=> !elimA; endproperty
   a_noelim: assert property (p_noelim) else $error("move wrongly eliminated");
   property p_merge; !mergeUopA && !mergeUopB; endproperty
   a_merge: assert property (p_merge) else $error("merge op inserted");
endmodule // ech_hazard_checker
bind ech_exec_hazard ech_hazard_checker #(.NEW_GEN(NEW_GEN)) i_ech_hazard_checker (.*);

//--- src/ech_exec_hazard.v
`timescale 1ns/1ps
// Notes on behaviour
// RL1 - Two same-stack micro-ops wanting writeback together: older wins, younger stalls.
// RL2 - Single-cycle move waits when a completing add holds the writeback bus.
// RL3 - Floating-point loads take one cycle more than ordinary loads.
// RL4 - Result crossing floating-point and SIMD stacks costs one extra cycle.
// RL5 - Packed single add delivers result with three cycles latency.
// RL6 - Packed bitwise and in integer SIMD delivers result in one cycle.
// RL7 - FP to integer SIMD bypass costs one cycle; back costs one more.
// RL8 - Partial register writes merge in hardware; no merge micro-op inserted.
// RL9 - Intermediate generation: high-byte operations steered only to ports 1 and 5.
// RL10 - Intermediate generation: high-byte operation itself has one cycle latency.
// RL11 - Dependents of high-byte operation wait one additional cycle.
// RL12 - Newest generation: high-byte operations port 1 only, three cycle latency.
// RL13 - Zero-latency move elimination needs free tracking slots, else runs normally.
// RL14 - Eligible moves finish in front end; byte, 16-bit, high-zx, sign-extend excluded.
// RL15 - Static generation parameter selects high-byte handling.
// RL16 - Each stack arbitrates writeback every cycle by age; losers retry next.
`include "ech_timing_regs.vh"
module ech_exec_hazard #(
   parameter NEW_GEN = 0
) (
   // Clock and reset
   input  wire       clk_sys,
   input  wire       rst_n,
   // Issue from dispatch, two candidates per cycle for one stack
   input  wire       issueAValid,
   input  wire [2:0] issueAOp,
   input  wire [1:0] issueASrcDom,
   input  wire [2:0] issueAMove,
   input  wire [2:0] issueAPort,
   input  wire [7:0] issueAAge,
   input  wire       issueAPartial,
   input  wire       issueBValid,
   input  wire [2:0] issueBOp,
   input  wire [1:0] issueBSrcDom,
   input  wire [2:0] issueBMove,
   input  wire [2:0] issueBPort,
   input  wire [7:0] issueBAge,
   input  wire       issueBPartial,
   // Move elimination slot release
   input  wire       elimRelease,
   // Results
   output reg        grantA,
   output reg        grantB,
   output reg        stallA,
   output reg        stallB,
   output reg  [3:0] latencyA,
   output reg  [3:0] latencyB,
   output reg  [2:0] portA,
   output reg  [2:0] portB,
   output reg        elimA,
   output reg        elimB,
   output reg        mergeUopA,
   output reg        mergeUopB,
   output reg  [2:0] elimFree
);

   // ****************************************
   // Helpers
   // ****************************************
   function [1:0] dom_of;
      input [2:0] op;
      begin
         case (op)
            `ECH_OP_FADD:  dom_of = `ECH_DOM_FP;
            `ECH_OP_PACKED_BITWISE_AND:  dom_of = `ECH_DOM_SIMD;
            default:       dom_of = `ECH_DOM_INT;
         endcase
      end
   endfunction

   function eligible;
      input [2:0] mv;
      begin
         eligible = (mv == `ECH_MV_R32) || (mv == `ECH_MV_R64) ||
                    (mv == `ECH_MV_VEC) || (mv == `ECH_MV_ZXLO); // [RL14]
      end
   endfunction

   // Full latency including domain crossing and load penalties
   function [3:0] lat_of;
      input [2:0] op;
      input [1:0] src;
      reg   [3:0] base;
      reg   [1:0] dst;
      begin
         dst = dom_of(op);
         case (op)
            `ECH_OP_FADD:  base = `ECH_LAT_FADD;                       // [RL5]
            `ECH_OP_PACKED_BITWISE_AND:  base = `ECH_LAT_PACKED_BITWISE_AND;                       // [RL6]
            `ECH_OP_LOAD:  base = (src == `ECH_DOM_FP) ?
                                  `ECH_LAT_LOAD + `ECH_LAT_FPLOAD_X :
                                  `ECH_LAT_LOAD;                       // [RL3]
            `ECH_OP_HBYTE: base = (NEW_GEN != 0) ? `ECH_LAT_HB_NEW :
                                  `ECH_LAT_HB_MID + `ECH_LAT_HB_DEP;   // [RL10] [RL11] [RL12]
            default:       base = `ECH_LAT_MOV;
         endcase
         // Each direction of FP/SIMD crossing pays its own cycle
         if ((src == `ECH_DOM_FP && dst == `ECH_DOM_SIMD) ||
             (src == `ECH_DOM_SIMD && dst == `ECH_DOM_FP))
            lat_of = base + `ECH_LAT_XDOM;                             // [RL4] [RL7]
         else
            lat_of = base;
      end
   endfunction

   // High-byte ops keep a port 5 request, else go to port 1, in the middle generation [RL15]
   function [2:0] port_of;
      input [2:0] op;
      input [2:0] req;
      begin
         if (op != `ECH_OP_HBYTE)
            port_of = req;
         else if (NEW_GEN != 0)
            port_of = `ECH_PORT_HB_A;                                  // [RL12]
         else if (req == `ECH_PORT_HB_B)
            port_of = `ECH_PORT_HB_B;                                  // [RL9]
         else
            port_of = `ECH_PORT_HB_A;                                  // [RL9]
      end
   endfunction

   // ****************************************
   // Slot helpers
   // ****************************************
   // Writeback slot that a result of this latency would land on
   function slot_free;
      input [7:0] busy;
      input [3:0] lat;
      begin
         slot_free = !busy[lat[2:0]];
      end
   endfunction

   // Claim mark for the next cycle, one lower because the vector ages by then
   function [7:0] slot_mark;
      input [3:0] lat;
      begin
         slot_mark = 8'h01 << (lat[2:0] - 3'h1);
      end
   endfunction

   // Move that may leave the scheduler while a tracking slot remains
   function elim_ok;
      input       valid;
      input [2:0] op;
      input [2:0] mv;
      input [2:0] slots;
      begin
         elim_ok = valid && (op == `ECH_OP_MOV) && eligible(mv) && (slots != 3'h0);
      end
   endfunction

   // ****************************************
   // Writeback bus reservation
   // ****************************************
   // Bit i set: bus is claimed i cycles from now by an earlier grant
   reg  [7:0] wbBusy;
   reg  [7:0] next_wbBusy;
   reg  [2:0] next_elimFree;
   reg        next_grantA;
   reg        next_grantB;
   reg        next_elimA;
   reg        next_elimB;
   reg  [3:0] latA;
   reg  [3:0] latB;
   reg        wantA;
   reg        wantB;
   reg        aOlder;
   reg        freeA;
   reg        freeB;

   always @* begin
      latA          = lat_of(issueAOp, issueASrcDom);
      latB          = lat_of(issueBOp, issueBSrcDom);
      next_elimFree = elimFree;
      next_elimA    = 1'b0;
      next_elimB    = 1'b0;
      // Moves only leave the scheduler while tracking slots remain
      if (elim_ok(issueAValid, issueAOp, issueAMove, next_elimFree)) begin
         next_elimA    = 1'b1;                                         // [RL13]
         next_elimFree = next_elimFree - 3'h1;
      end
      if (elim_ok(issueBValid, issueBOp, issueBMove, next_elimFree)) begin
         next_elimB    = 1'b1;                                         // [RL13]
         next_elimFree = next_elimFree - 3'h1;
      end
      if (elimRelease && next_elimFree != `ECH_ELIM_SLOTS)
         next_elimFree = next_elimFree + 3'h1;
      wantA  = issueAValid && !next_elimA;
      wantB  = issueBValid && !next_elimB;
      aOlder = (issueAAge <= issueBAge);
      // Slot already claimed by an add completing then stalls the move
      freeA  = slot_free(wbBusy, latA);                                // [RL2]
      freeB  = slot_free(wbBusy, latB);                                // [RL2]
      next_grantA = 1'b0;
      next_grantB = 1'b0;
      next_wbBusy = {1'b0, wbBusy[7:1]};
      if (wantA && wantB && latA == latB) begin
         if (aOlder)
            next_grantA = freeA;                                       // [RL1]
         else
            next_grantB = freeB;                                       // [RL1]
      end else begin
         next_grantA = wantA && freeA;                                 // [RL16]
         next_grantB = wantB && freeB;                                 // [RL16]
      end
      if (next_grantA)
         next_wbBusy = next_wbBusy | slot_mark(latA);
      if (next_grantB)
         next_wbBusy = next_wbBusy | slot_mark(latB);
   end

   // ****************************************
   // Result next values
   // ****************************************
   reg        next_stallA;
   reg        next_stallB;
   reg  [3:0] next_latencyA;
   reg  [3:0] next_latencyB;
   reg  [2:0] next_portA;
   reg  [2:0] next_portB;
   reg        next_mergeUopA;
   reg        next_mergeUopB;

   always @* begin
      // Stalled ops stay ready upstream and retry next cycle
      next_stallA    = wantA && !next_grantA;                          // [RL16]
      next_stallB    = wantB && !next_grantB;                          // [RL16]
      // Eliminated moves never reach a port, so they report no latency
      next_latencyA  = next_elimA ? `ECH_LAT_ZERO : latA;              // [RL13]
      next_latencyB  = next_elimB ? `ECH_LAT_ZERO : latB;              // [RL13]
      next_portA     = port_of(issueAOp, issueAPort);                  // [RL9] [RL12]
      next_portB     = port_of(issueBOp, issueBPort);                  // [RL9] [RL12]
      // Partial writes merge in the datapath; no extra op ever requested
      next_mergeUopA = 1'b0 & issueAPartial;                           // [RL8]
      next_mergeUopB = 1'b0 & issueBPartial;                           // [RL8]
   end

   // ****************************************
   // Output registers
   // ****************************************
   // Busy vector shifts every cycle, idle or not; slot count changes only on elimination or release
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         wbBusy   <= 8'h00;
         elimFree <= `ECH_ELIM_SLOTS;
      end else begin
         wbBusy   <= next_wbBusy;
         elimFree <= next_elimFree;
      end
   end

   // A loser's stall stands one cycle; dispatch re-presents it
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         grantA <= 1'b0;
         grantB <= 1'b0;
         stallA <= 1'b0;
         stallB <= 1'b0;
      end else begin
         grantA <= next_grantA;
         grantB <= next_grantB;
         stallA <= next_stallA;                                        // [RL16]
         stallB <= next_stallB;                                        // [RL16]
      end
   end

   // Port is reported even for a stalled op so dispatch can retry it there
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         latencyA <= 4'h0;
         latencyB <= 4'h0;
         portA    <= 3'h0;
         portB    <= 3'h0;
      end else begin
         latencyA <= next_latencyA;
         latencyB <= next_latencyB;
         portA    <= next_portA;
         portB    <= next_portB;
      end
   end

   // Elimination and merge flags
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         elimA     <= 1'b0;
         elimB     <= 1'b0;
         mergeUopA <= 1'b0;
         mergeUopB <= 1'b0;
      end else begin
         elimA     <= next_elimA;                                      // [RL14]
         elimB     <= next_elimB;                                      // [RL14]
         mergeUopA <= next_mergeUopA;                                  // [RL8]
         mergeUopB <= next_mergeUopB;                                  // [RL8]
      end
   end

endmodule // ech_exec_hazard

//--- src/ech_timing_regs.vh
`ifndef ECH_TIMING_REGS_VH
`define ECH_TIMING_REGS_VH
// ****************************************
// Latency and encoding constants
// ****************************************
`define ECH_LAT_FADD      4'h3
`define ECH_LAT_PACKED_BITWISE_AND      4'h1
`define ECH_LAT_LOAD      4'h1
`define ECH_LAT_FPLOAD_X  4'h1
`define ECH_LAT_XDOM      4'h1
`define ECH_LAT_HB_MID    4'h1
`define ECH_LAT_HB_NEW    4'h3
`define ECH_LAT_HB_DEP    4'h1
`define ECH_LAT_MOV       4'h1
`define ECH_LAT_ZERO      4'h0
`define ECH_PORT_HB_A     3'h1
`define ECH_PORT_HB_B     3'h5
`define ECH_OP_ALU        3'h0
`define ECH_OP_FADD       3'h1
`define ECH_OP_PACKED_BITWISE_AND       3'h2
`define ECH_OP_LOAD       3'h3
`define ECH_OP_MOV        3'h4
`define ECH_OP_HBYTE      3'h5
`define ECH_DOM_INT       2'h0
`define ECH_DOM_FP        2'h1
`define ECH_DOM_SIMD      2'h2
`define ECH_MV_R32        3'h0
`define ECH_MV_R64        3'h1
`define ECH_MV_VEC        3'h2
`define ECH_MV_ZXLO       3'h3
`define ECH_MV_BYTE       3'h4
`define ECH_MV_W16        3'h5
`define ECH_MV_ZXHI       3'h6
`define ECH_MV_SX         3'h7
`define ECH_ELIM_SLOTS    3'h4
`endif
